// ### iocsp_pkg.sv
/*
 * Shared constants and carrier types for the I/O channel sequencer.
 * Assumes a single 100 MHz clock and an Avalon-MM host with 32-bit data.
 */
`default_nettype none
package iocsp_pkg;
    // ==========================================================
    // bus map, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h4;
    localparam logic [3:0] ADDR_LEVELS = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    // ==========================================================
    // control register fields
    localparam int CTRL_LOAD  = 0;
    localparam int CTRL_DISP  = 1;
    localparam int CTRL_INIT_LOAD = 2;
    localparam int CTRL_CLEAR = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // ==========================================================
    // interrupt levels: 0 check, 1..24 maskable 0..23, 25 trace, 26 engineer
    localparam int NUM_LEVELS  = 27;
    localparam int NUM_MASKED  = 24;
    localparam int LVL_CHECK   = 0;
    localparam int LVL_TRACE   = 25;
    localparam int LVL_ENGR    = 26;
    localparam int GRP_A_BITS  = 15;
    localparam int GRP_B_BITS  = 12;
    localparam logic [23:0] MASK_RESET = 24'hFF_FFFF;
    // ==========================================================
    // phases and function codes
    localparam logic [2:0] PH0 = 3'h0;
    localparam logic [2:0] PH1 = 3'h1;
    localparam logic [2:0] PH2 = 3'h2;
    localparam logic [2:0] PH3 = 3'h3;
    localparam logic [2:0] PH4 = 3'h4;
    localparam logic [2:0] PH5 = 3'h5;
    localparam logic [2:0] PH6 = 3'h6;
    localparam logic [2:0] PH7 = 3'h7;
    localparam logic [2:0] FN_WRITE  = 3'h1;
    localparam logic [2:0] FN_READ   = 3'h2;
    localparam logic [2:0] FN_SINT   = 3'h3;
    localparam logic [2:0] FN_CTRL   = 3'h4;
    localparam logic [2:0] FN_IWRITE = 3'h5;
    localparam logic [2:0] FN_IREAD  = 3'h6;
    localparam logic [2:0] FN_SDEV   = 3'h7;
    localparam logic [1:0] ECYC_1 = 2'h1;
    localparam logic [1:0] ECYC_2 = 2'h2;
    localparam logic [1:0] ECYC_3 = 2'h3;

    typedef struct packed {
        logic       t_valid;
        logic [2:0] t_phase;
        logic       x_valid;
        logic [2:0] x_phase;
    } iocsp_phase_t;

    typedef struct packed {
        logic       io_start;
        logic [2:0] func_bits;
        logic       i1_cycle;
        logic       i2_cycle;
        logic       wait_state;
        logic       timer_shift;
        logic       brstore_instr;
        logic       instr_done;
        logic       brstore_done;
    } iocsp_cpu_t;

    typedef struct packed {
        logic write;
        logic read;
        logic sense_int;
        logic control;
        logic init_write;
        logic init_read;
        logic sense_dev;
    } iocsp_func_t;
endpackage : iocsp_pkg
`default_nettype wire

// ### iocsp_sequencer.sv
/*
 * Channel sequencer: function register and decode, execute-I/O cycle flags,
 * adapter timing pulses A/B/C, interrupt polling, level latches and forced
 * branch-and-store request, with an Avalon-MM register slave.
 * Assumes phase strobes and cpu state come from logic on the same clock;
 * the shared input bus comes from adapter pins and is synchronised here.
 */
// Behaviour
// - function register loads at 5, clears after transfer
// - seven decoded outputs, one per function code
// - command flag on from E1 start to T7
// - non read/write transfer flag at T0 of E2
// - read/write transfer flag T0 of E3, off T7
// - read/write fetch address word E2, data E3
// - initialize commands load channel address in E2
// - control and sense exchange data in E2
// - pulse A on at phase 1, off at 5
// - pulse B on at 3 after A, off at 7
// - pulse C on at 0 and 4, off 2, 6
// - sixteen bus lines shared by two level groups
// - two poll signals, one per group, at 1 and 5
// - masked levels are never latched
// - any latched level stops polling, freezes selector
// - forced indirect branch-and-store, no storage, counter held
// - reset clears gate, selects levels 14-23 group
// - poll only while gated; first fetch only at 5
// - polling continues during wait via timer shift
// - polling suppressed in listed instructions and modes
// - poll 0-13 from 1 to 5, 14-23 5 to 1
// - reset sets all masks, clears all levels
// - fixed priority check, 0..23, trace, engineer
`default_nettype none
module iocsp_sequencer (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire iocsp_pkg::iocsp_phase_t phase,
    input  wire iocsp_pkg::iocsp_cpu_t   cpu,
    input  wire logic [15:0]         in_bus,
    output iocsp_pkg::iocsp_func_t   func_decode,
    output logic                     io_command_cycle_flag,
    output logic                     io_transfer_cycle_flag,
    output logic                     fetch_addr_to_acc,
    output logic                     load_chan_addr,
    output logic                     exchange_word,
    output logic                     data_word_xfer,
    output logic                     pulse_a,
    output logic                     pulse_b,
    output logic                     pulse_c,
    output logic                     poll_low_group,
    output logic                     poll_high_group,
    output logic                     any_interrupt,
    output logic                     branch_store_instruction,
    output logic                     inhibit_storage,
    output logic                     hold_counter,
    output logic      [4:0]          vector_level
);
    import iocsp_pkg::*;

    // ==========================================================
    // phase decode
    function automatic logic hit(input iocsp_phase_t p, input logic [2:0] n);
        hit = (p.t_valid && p.t_phase == n) || (p.x_valid && p.x_phase == n);
    endfunction

    wire ph0 = hit(phase, PH0);
    wire ph1 = hit(phase, PH1);
    wire ph2 = hit(phase, PH2);
    wire ph3 = hit(phase, PH3);
    wire ph4 = hit(phase, PH4);
    wire ph5 = hit(phase, PH5);
    wire ph6 = hit(phase, PH6);
    wire ph7 = hit(phase, PH7);

    // ==========================================================
    // execute-I/O sequencing
    logic [2:0] func_reg;
    logic [1:0] ecyc;
    logic       io_active;

    // one driver for the whole struct, so no partial drives of one variable
    assign func_decode = '{write:      func_reg == FN_WRITE,
                           read:       func_reg == FN_READ,
                           sense_int:  func_reg == FN_SINT,
                           control:    func_reg == FN_CTRL,
                           init_write: func_reg == FN_IWRITE,
                           init_read:  func_reg == FN_IREAD,
                           sense_dev:  func_reg == FN_SDEV};

    wire rw_cmd   = func_decode.write || func_decode.read;
    wire init_cmd = func_decode.init_write || func_decode.init_read;
    wire xfer_on  = ph0 && io_active && !io_transfer_cycle_flag
                    && (rw_cmd ? ecyc == ECYC_3 : ecyc == ECYC_2);
    wire xfer_end = io_transfer_cycle_flag && ph7;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            func_reg               <= 3'h0;
            ecyc                   <= 2'h0;
            io_active              <= 1'b0;
            io_command_cycle_flag  <= 1'b0;
            io_transfer_cycle_flag <= 1'b0;
        end else if (clk_en) begin
            if (cpu.io_start) begin
                io_active             <= 1'b1;
                ecyc                  <= ECYC_1;
                io_command_cycle_flag <= 1'b1;
            end else if (io_active && ph7) begin
                io_command_cycle_flag <= 1'b0;
                if (xfer_end)
                    io_active <= 1'b0;
                else
                    ecyc <= ecyc + 2'h1;
            end
            if (io_command_cycle_flag && ph5)
                func_reg <= cpu.func_bits;
            else if (xfer_end)
                func_reg <= 3'h0;
            if (xfer_on)
                io_transfer_cycle_flag <= 1'b1;
            else if (xfer_end)
                io_transfer_cycle_flag <= 1'b0;
        end
    end

    // the address word of a read/write lands in the accumulator, not the channel
    assign fetch_addr_to_acc = io_active && rw_cmd && ecyc == ECYC_2;
    assign data_word_xfer    = io_transfer_cycle_flag && rw_cmd;
    assign load_chan_addr    = io_transfer_cycle_flag && init_cmd;
    assign exchange_word     = io_transfer_cycle_flag
                               && (func_decode.control || func_decode.sense_int
                                   || func_decode.sense_dev);

    // ==========================================================
    // adapter timing pulses
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pulse_a <= 1'b0;
            pulse_b <= 1'b0;
            pulse_c <= 1'b0;
        end else if (clk_en) begin
            if (ph1)
                pulse_a <= 1'b1;
            else if (ph5)
                pulse_a <= 1'b0;
            if (ph3 && pulse_a)
                pulse_b <= 1'b1;
            else if (ph7 && !pulse_a)
                pulse_b <= 1'b0;
            if (ph0 || ph4)
                pulse_c <= 1'b1;
            else if (ph2 || ph6)
                pulse_c <= 1'b0;
        end
    end

    // ==========================================================
    // input bus synchroniser
    logic [15:0] bus_meta;
    logic [15:0] bus_sync;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_meta <= 16'h0000;
            bus_sync <= 16'h0000;
        end else if (clk_en) begin
            bus_meta <= in_bus;
            bus_sync <= bus_meta;
        end
    end

    // ==========================================================
    // register file
    logic [3:0]            ctrl;
    logic [23:0]           mask;
    logic [NUM_LEVELS-1:0] levels;
    logic                  ack;
    logic                  gate_poll;
    logic                  poll_sel;   // high selects levels 0-13
    logic                  brstore_pend;

    wire req       = avs_read || avs_write;
    wire wr_take   = avs_write && ack && clk_en;
    wire wr_ctrl   = wr_take && avs_address == ADDR_CTRL;
    wire wr_mask   = wr_take && avs_address == ADDR_MASK;
    wire wr_levels = wr_take && avs_address == ADDR_LEVELS;
    assign avs_waitrequest = req && !ack;

    wire [31:0] status_word = {16'h0000, 2'h0, brstore_pend, any_interrupt,
                               poll_sel, gate_poll, io_transfer_cycle_flag,
                               io_command_cycle_flag, 5'h00, func_reg};
    wire [31:0] rd_mux = (avs_address == ADDR_CTRL)   ? {28'h000_0000, ctrl} :
                         (avs_address == ADDR_MASK)   ? {8'h00, mask} :
                         (avs_address == ADDR_LEVELS) ? {5'h00, levels} :
                         (avs_address == ADDR_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            ctrl         <= CTRL_RESET;
            mask         <= MASK_RESET;
        end else if (clk_en) begin
            ack <= req && !ack;
            if (avs_read && !ack)
                avs_readdata <= rd_mux;
            if (wr_ctrl)
                ctrl <= avs_writedata[3:0];
            if (wr_mask)
                mask <= avs_writedata[23:0];
        end
    end

    // ==========================================================
    // polling
    // timer shift stands in for stopped phase clocks during wait
    wire suppress = io_active || cpu.brstore_instr || ctrl[CTRL_LOAD] || ctrl[CTRL_DISP]
                    || ctrl[CTRL_INIT_LOAD] || ctrl[CTRL_CLEAR];
    wire wait_shift = cpu.wait_state && cpu.timer_shift;
    // a shift with the gate off reopens it: a frozen selector must not stall wait polling
    wire step_t1  = (ph1 && !cpu.i1_cycle) || (wait_shift && (!poll_sel || !gate_poll));
    wire step_t5  = ph5 || (wait_shift && poll_sel);
    wire latch_a  = gate_poll && poll_sel && step_t5;
    wire latch_b  = gate_poll && !poll_sel && step_t1;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gate_poll <= 1'b0;
            poll_sel  <= 1'b0;
        end else if (clk_en) begin
            if (suppress || any_interrupt)
                gate_poll <= 1'b0;
            else if (step_t1) begin
                gate_poll <= 1'b1;
                poll_sel  <= 1'b1;
            end else if (step_t5 && gate_poll)
                poll_sel  <= 1'b0;
        end
    end

    assign poll_low_group  = gate_poll && poll_sel;
    assign poll_high_group = gate_poll && !poll_sel;

    // ==========================================================
    // level latches; bus lines are valid only while polled
    logic [NUM_LEVELS-1:0] grp_set;
    wire  [NUM_LEVELS-1:0] enable_mask = {2'b11, ~mask, 1'b1};
    always_comb begin
        grp_set = '0;
        if (latch_a)
            grp_set[GRP_A_BITS-1:0] = bus_sync[GRP_A_BITS-1:0];
        if (latch_b)
            grp_set[NUM_LEVELS-1:GRP_A_BITS] = bus_sync[GRP_B_BITS-1:0];
    end
    wire [NUM_LEVELS-1:0] next_levels =
        (levels & ~(wr_levels ? avs_writedata[NUM_LEVELS-1:0] : '0))
        | (grp_set & enable_mask);

    // lowest index wins
    function automatic logic [4:0] prio(input logic [NUM_LEVELS-1:0] v);
        prio = 5'h00;
        for (int i = NUM_LEVELS - 1; i >= 0; i--)
            if (v[i])
                prio = 5'(i);
    endfunction

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            levels       <= '0;
            brstore_pend <= 1'b0;
            vector_level <= 5'h00;
        end else if (clk_en) begin
            levels <= next_levels;
            if (cpu.instr_done && any_interrupt && !brstore_pend) begin
                brstore_pend <= 1'b1;
                vector_level <= prio(levels);
            end else if (cpu.brstore_done)
                brstore_pend <= 1'b0;
        end
    end

    assign any_interrupt            = |levels;
    assign branch_store_instruction = brstore_pend;
    assign inhibit_storage          = brstore_pend && (cpu.i1_cycle || cpu.i2_cycle);
    assign hold_counter             = inhibit_storage;

    // ==========================================================
    // checks
    func_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && io_command_cycle_flag && ph5 && !cpu.io_start
        |=> func_reg == $past(cpu.func_bits))
        else $error("function register not loaded at phase 5");
    cmd_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && io_command_cycle_flag && ph7 && !cpu.io_start |=> !io_command_cycle_flag)
        else $error("command flag not dropped at phase 7");
    xfer_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(io_transfer_cycle_flag) |-> ecyc == (rw_cmd ? ECYC_3 : ECYC_2))
        else $error("transfer flag rose in wrong execute cycle");
    pulse_b_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(pulse_b) |-> $past(pulse_a) && $past(ph3))
        else $error("pulse B rose without pulse A at phase 3");
    pulse_c_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && (ph0 || ph4) |=> pulse_c)
        else $error("pulse C not set on phase 0 or 4");
    mask_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        ((levels[NUM_MASKED:1] & ~$past(levels[NUM_MASKED:1])) & $past(mask)) == 24'h00_0000)
        else $error("masked level was latched");
    poll_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && any_interrupt |=> !gate_poll && poll_sel == $past(poll_sel))
        else $error("polling continued after interrupt");
    reset_poll_a: assert property (@(posedge clock)
        sys_rst |=> !gate_poll && !poll_sel && levels == '0 && mask == MASK_RESET)
        else $error("reset state of polling wrong");
    suppress_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && suppress |=> !poll_low_group && !poll_high_group)
        else $error("polling during suppressed state");
    first_fetch_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && cpu.i1_cycle && !cpu.wait_state && !gate_poll |=> !gate_poll)
        else $error("polling opened in first fetch cycle");
endmodule : iocsp_sequencer
`default_nettype wire

// ### iocsp_adapters.sv
/*
 * adapter-side model: puts pending interrupt requests on the shared
 * input bus while the matching level group is polled.
 * assumes the same clock as the sequencer and no pull-ups on the bus.
 */
`default_nettype none
module iocsp_adapters (
    input  wire logic        clock,
    input  wire logic        slow,
    input  wire logic        poll_low_group,
    input  wire logic        poll_high_group,
    input  wire logic [14:0] low_req,
    input  wire logic [11:0] high_req,
    output logic      [15:0] in_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] idle   = 16'hA5A5;
    logic        low_d  = 1'b0;
    logic        high_d = 1'b0;
    logic        low_on;
    logic        high_on;
    // ==========================================================
    // released lines toggle every cycle so a stray sample never reads clean
    always @(posedge clock) begin
        idle   <= ~idle;
        low_d  <= poll_low_group;
        high_d <= poll_high_group;
    end
    // slow adapters answer one cycle into the poll window
    assign low_on  = poll_low_group && (!slow || low_d);
    assign high_on = poll_high_group && (!slow || high_d);
    assign in_bus  = low_on ? {idle[15], low_req}
                   : high_on ? {idle[15:12], high_req} : idle;
endmodule // iocsp_adapters
`default_nettype wire

// ### iocsp_tb.sv
/*
 * self-checking bench for iocsp_sequencer: pulses, execute-io, polling.
 * assumes iocsp_pkg and iocsp_adapters are compiled first.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import iocsp_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    iocsp_phase_t phase = '0;
    iocsp_cpu_t cpu = '0;
    iocsp_func_t func_decode;
    logic [15:0] in_bus;
    logic [14:0] low_req = 15'h0000;
    logic [11:0] high_req = 12'h000;
    logic [4:0] vector_level;
    logic io_command_cycle_flag, io_transfer_cycle_flag, fetch_addr_to_acc;
    logic load_chan_addr, exchange_word, data_word_xfer, pulse_a, pulse_b, pulse_c;
    logic poll_low_group, poll_high_group, any_interrupt, branch_store_instruction;
    logic inhibit_storage, hold_counter;
    logic slow = 1'b0, run_ph = 1'b1, jit = 1'b0, half = 1'b0;
    logic e_a = 1'b0, e_b = 1'b0, e_c = 1'b0, e_p = 1'b0;
    logic [1:0] lp = 2'b00;
    logic [2:0] ph_cnt = 3'h0;
    int unsigned err_total = 0, compares = 0;

    iocsp_sequencer dut_u (.clock, .sys_rst, .clk_en, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .phase, .cpu,
        .in_bus, .func_decode, .io_command_cycle_flag, .io_transfer_cycle_flag,
        .fetch_addr_to_acc, .load_chan_addr, .exchange_word, .data_word_xfer,
        .pulse_a, .pulse_b, .pulse_c, .poll_low_group, .poll_high_group,
        .any_interrupt, .branch_store_instruction, .inhibit_storage,
        .hold_counter, .vector_level);
    iocsp_adapters adp_u (.clock, .slow, .poll_low_group, .poll_high_group,
        .low_req, .high_req, .in_bus);

    // ==========================================================
    // checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // a hung handshake is left to the watchdog
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic hit(input logic [2:0] n);
        return (phase.t_valid && phase.t_phase == n) || (phase.x_valid && phase.x_phase == n);
    endfunction
    task automatic to_ph(input logic [2:0] n);
        do begin
            @(posedge clock);
        end while (!hit(n));
    endtask
    task automatic at_ph(input logic [2:0] n);
        to_ph(n);
        @(posedge clock);
        @(negedge clock);
    endtask

    // ==========================================================
    // phase strobes on either clock, junk in the unused field
    always #5 clock = ~clock;
    always @(posedge clock) clk_en <= !(jit && ($urandom % 8 == 0));
    always @(posedge clock) begin
        if (sys_rst) ph_cnt <= 3'h0;
        if (sys_rst || !run_ph || !half) begin
            half <= !sys_rst && run_ph;
            phase <= {1'b0, 3'($urandom), 1'b0, 3'($urandom)};
        end else begin
            half <= 1'b0;
            ph_cnt <= ph_cnt + 3'h1;
            if ($urandom % 2) phase <= {1'b0, 3'($urandom), 1'b1, ph_cnt};
            else phase <= {1'b1, ph_cnt, 1'b0, 3'($urandom)};
        end
    end
    always @(posedge clock) begin
        if (sys_rst) {e_a, e_b, e_c} <= 3'b000;
        else if (clk_en) begin
            if (hit(3'h1)) e_a <= 1'b1;
            if (hit(3'h5)) e_a <= 1'b0;
            if (hit(3'h3) && e_a) e_b <= 1'b1;
            if (hit(3'h7) && !e_a) e_b <= 1'b0;
            if (hit(3'h0) || hit(3'h4)) e_c <= 1'b1;
            if (hit(3'h2) || hit(3'h6)) e_c <= 1'b0;
        end
    end
    // a poll line may only rise right after a phase 1 or 5 strobe or a wait shift
    always @(posedge clock) begin
        lp <= {poll_low_group, poll_high_group};
        e_p <= hit(3'h1) || hit(3'h5) || cpu.timer_shift;
    end
    always @(negedge clock) if (!sys_rst) begin
        chk({pulse_a, pulse_b, pulse_c}, {e_a, e_b, e_c});
        chk((poll_low_group & poll_high_group)
            | ((|({poll_low_group, poll_high_group} & ~lp)) & !e_p), 1'b0);
    end

    // ==========================================================
    // scenarios
    task automatic io_cmd(input logic [2:0] fn);
        logic rw;
        rw = (fn == FN_READ || fn == FN_WRITE);
        to_ph(3'h7);
        cpu.io_start <= 1'b1;
        cpu.func_bits <= fn;
        @(posedge clock);
        cpu.io_start <= 1'b0;
        at_ph(3'h5);
        chk(io_command_cycle_flag, 1'b1);
        chk(func_decode, 7'h40 >> (fn - 3'h1));
        @(posedge clock);
        cpu.func_bits <= 3'($urandom);
        at_ph(3'h7);
        chk(io_command_cycle_flag, 1'b0);
        at_ph(3'h0);
        chk(io_transfer_cycle_flag, !rw);
        chk({poll_low_group, poll_high_group}, 2'b00);
        chk({fetch_addr_to_acc, load_chan_addr, exchange_word}, {rw, fn == FN_IWRITE ||
            fn == FN_IREAD, fn == FN_SINT || fn == FN_CTRL || fn == FN_SDEV});
        if (rw) begin
            at_ph(3'h7);
            chk(io_transfer_cycle_flag, 1'b0);
            at_ph(3'h0);
            chk({io_transfer_cycle_flag, data_word_xfer}, 2'b11);
        end
        at_ph(3'h7);
        chk({io_transfer_cycle_flag, func_decode}, 8'h00);
        @(posedge clock);
    endtask
    function automatic logic [4:0] low_idx(input logic [26:0] v);
        low_idx = 5'h00;
        for (int i = 26; i >= 0; i--) if (v[i]) low_idx = 5'(i);
    endfunction
    task automatic trial(input logic g, input logic [14:0] rq, input logic [23:0] m);
        logic [26:0] ev;
        ev = (g ? {rq[11:0], 15'h0000} : {12'h000, rq}) & ~{2'b00, m, 1'b0};
        slow <= 1'($urandom);
        bus(1'b1, ADDR_MASK, {8'h00, m});
        if (g) high_req <= rq[11:0];
        else low_req <= rq;
        jit <= 1'b1;
        cyc(64);
        jit <= 1'b0;
        low_req <= 15'h0000;
        high_req <= 12'h000;
        cyc(2);
        bus(1'b0, ADDR_LEVELS, 32'h0000_0000);
        chk(rd, {5'h00, ev});
        chk(any_interrupt, |ev);
        if (|ev) chk({poll_low_group, poll_high_group}, 2'b00);
        cpu.instr_done <= 1'b1;
        cpu.i1_cycle <= 1'b1;
        @(posedge clock);
        cpu.instr_done <= 1'b0;
        cyc(1);
        @(negedge clock);
        chk({branch_store_instruction, inhibit_storage, hold_counter}, {3{|ev}});
        if (|ev) chk(vector_level, low_idx(ev));
        @(posedge clock);
        cpu.brstore_done <= 1'b1;
        cpu.i1_cycle <= 1'b0;
        @(posedge clock);
        cpu.brstore_done <= 1'b0;
        bus(1'b1, ADDR_LEVELS, 32'h07FF_FFFF);
        @(negedge clock);
        chk({any_interrupt, branch_store_instruction}, 2'b00);
        @(posedge clock);
    endtask

    initial begin
        void'($urandom(30));
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(rd[11:10], 2'b00);
        for (int k = 0; k < 40 && !(poll_low_group | poll_high_group); k++) @(posedge clock);
        chk(poll_low_group, 1'b1);
        bus(1'b0, ADDR_MASK, 32'h0000_0000);
        chk(rd, 32'h00FF_FFFF);
        bus(1'b0, ADDR_LEVELS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int fn = 1; fn < 8; fn++) io_cmd(3'(fn));
        trial(1'b0, 15'h0010, 24'hFF_FFFF);
        trial(1'b0, 15'h0010, 24'hFF_FFF7);
        trial(1'b0, 15'h4205, 24'h00_0000);
        trial(1'b1, 15'h0C01, 24'h00_0000);
        trial(1'b1, 15'h0C00, 24'hFF_FFFF);
        repeat (20) trial(1'($urandom), 15'($urandom), 24'($urandom));
        for (int s = 0; s < 5; s++) begin
            if (s < 4) bus(1'b1, ADDR_CTRL, 32'h0000_0001 << s);
            else cpu.brstore_instr <= 1'b1;
            low_req <= 15'h0001;
            cyc(64);
            chk({any_interrupt, poll_low_group, poll_high_group}, 3'b000);
            cpu.brstore_instr <= 1'b0;
            bus(1'b1, ADDR_CTRL, 32'h0000_0000);
            cyc(64);
            chk(any_interrupt, 1'b1);
            low_req <= 15'h0000;
            cyc(4);
            bus(1'b1, ADDR_LEVELS, 32'h07FF_FFFF);
        end
        // clocks stopped: only the timer shift can step the polling
        run_ph <= 1'b0;
        cpu.wait_state <= 1'b1;
        high_req <= 12'h800;
        for (int i = 0; i < 8; i++) begin
            cpu.timer_shift <= 1'b1;
            @(posedge clock);
            cpu.timer_shift <= 1'b0;
            cyc(5);
        end
        chk(any_interrupt, 1'b1);
        stop_test();
    end
    initial begin
        #200_000;
        err_total++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
